/* fcd_ctrl.sv */
// fcd_ctrl.sv: APB-driven controller that issues command sequences to a parallel NOR flash
// assumes a synchronous flash data bus and a ready/busy line already pulled up outside
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "fcd_map.svh"
module fcd_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic [21:0]      flash_addr,
  output logic [15:0]      flash_dq_o,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_i,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  input  wire logic        ready_busy_in
);
  fcd_pkg::fcd_ctl_t q;
  fcd_pkg::fcd_ctl_t n;
  logic              c_done;
  logic [15:0]       c_rdata;
  logic              acc;
  logic              wr_take;
  logic              go;
  logic              target;
  fcd_pkg::fcd_step_t s;

  // ----------------------------------------
  // sequence table
  // ----------------------------------------
  function automatic fcd_pkg::fcd_step_t mk(input fcd_pkg::fcd_kind_t k, input logic [11:0] a,
                                            input logic [7:0] d);
    mk = '{kind: k, addr: a, data: d};
  endfunction : mk

  function automatic fcd_pkg::fcd_step_t fcd_step(input fcd_pkg::fcd_cmd_t c, input logic [2:0] i);
    fcd_pkg::fcd_step_t r;
    r = mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);
    // every long sequence opens with the two unlock writes
    if (i == 3'h0 || i == 3'h3) begin
      r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_UNL1);  // R01
    end else if (i == 3'h1 || i == 3'h4) begin
      r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A2, `FCD_D_UNL2);  // R01
    end
    case (c)
      fcd_pkg::FCD_C_READ: r = (i == 3'h0) ? mk(fcd_pkg::FCD_K_RD, 12'h000, 8'h00) : mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);  // R03
      fcd_pkg::FCD_C_RESET: r = (i == 3'h0) ? mk(fcd_pkg::FCD_K_W, 12'h000, `FCD_D_RST) : mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);  // R04
      fcd_pkg::FCD_C_SUSP: r = (i == 3'h0) ? mk(fcd_pkg::FCD_K_W, 12'h000, `FCD_D_SUSP) : mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);  // R14
      fcd_pkg::FCD_C_RESUME: r = (i == 3'h0) ? mk(fcd_pkg::FCD_K_W, 12'h000, `FCD_D_SECT) : mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);  // R16
      fcd_pkg::FCD_C_CFI: r = (i == 3'h0) ? mk(fcd_pkg::FCD_K_W, `FCD_CFI_A, `FCD_D_CFI) : mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);  // R17
      fcd_pkg::FCD_C_BYP_PROG: begin
        if (i == 3'h0) r = mk(fcd_pkg::FCD_K_W, 12'h000, `FCD_D_PROG);  // R10
        else if (i == 3'h1) r = mk(fcd_pkg::FCD_K_WU, 12'h000, 8'h00);
        else r = mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);
      end
      fcd_pkg::FCD_C_BYP_OFF: begin
        if (i == 3'h0) r = mk(fcd_pkg::FCD_K_W, 12'h000, `FCD_D_ASEL);  // R11
        else if (i == 3'h1) r = mk(fcd_pkg::FCD_K_W, 12'h000, `FCD_D_ZERO);
        else r = mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);
      end
      fcd_pkg::FCD_C_ASEL, fcd_pkg::FCD_C_PROG, fcd_pkg::FCD_C_BYP_ON, fcd_pkg::FCD_C_SEC_ON,
      fcd_pkg::FCD_C_SEC_OFF: begin
        if (i == 3'h2) begin
          case (c)
            fcd_pkg::FCD_C_ASEL:   r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_ASEL);  // R05
            fcd_pkg::FCD_C_PROG:   r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_PROG);  // R08
            fcd_pkg::FCD_C_BYP_ON: r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_BYP);  // R10
            fcd_pkg::FCD_C_SEC_ON: r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_SECR);
            default:               r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_ASEL);
          endcase
        end else if (i == 3'h3) begin
          case (c)
            fcd_pkg::FCD_C_ASEL:    r = mk(fcd_pkg::FCD_K_RD, 12'h000, 8'h00);  // R02
            fcd_pkg::FCD_C_PROG:    r = mk(fcd_pkg::FCD_K_WU, 12'h000, 8'h00);  // R08
            fcd_pkg::FCD_C_SEC_OFF: r = mk(fcd_pkg::FCD_K_W, 12'h000, `FCD_D_ZERO);
            default:                r = mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);
          endcase
        end else if (i > 3'h3) begin
          r = mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);
        end
      end
      fcd_pkg::FCD_C_CHIP, fcd_pkg::FCD_C_SECT: begin
        if (i == 3'h2) r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_ESET);  // R12
        else if (i == 3'h5 && c == fcd_pkg::FCD_C_CHIP) r = mk(fcd_pkg::FCD_K_W, `FCD_UNL_A1, `FCD_D_CHIP);
        else if (i == 3'h5) r = mk(fcd_pkg::FCD_K_WA, 12'h000, `FCD_D_SECT);
        else if (i > 3'h5) r = mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);
      end
      default: r = mk(fcd_pkg::FCD_K_END, 12'h000, 8'h00);
    endcase
    fcd_step = r;
  endfunction : fcd_step

  function automatic logic is_poll(input fcd_pkg::fcd_cmd_t c);
    is_poll = (c == fcd_pkg::FCD_C_PROG) || (c == fcd_pkg::FCD_C_BYP_PROG) ||
              (c == fcd_pkg::FCD_C_CHIP) || (c == fcd_pkg::FCD_C_SECT);
  endfunction : is_poll

  // ----------------------------------------
  // control
  // ----------------------------------------
  always_comb begin
    n         = q;
    n.c_start = 1'b0;
    n.rdy     = ready_busy_in;
    s         = fcd_step(q.cmd, q.idx);
    acc       = psel && penable && q.pready;
    wr_take   = acc && pwrite;
    go        = wr_take && paddr == `FCD_OFS_CTRL && pwdata[`FCD_CTRL_GO] && !q.busy;
    // program polls against the written bit, erase polls for a one
    target    = is_poll(q.cmd) && (q.cmd == fcd_pkg::FCD_C_PROG || q.cmd == fcd_pkg::FCD_C_BYP_PROG) ?
                q.wdata[`FCD_BIT_POLL] : 1'b1;
    if (wr_take && !q.busy) begin
      case (paddr)
        `FCD_OFS_CTRL:  n.cmd   = fcd_pkg::fcd_cmd_t'(pwdata[3:0]);
        `FCD_OFS_ADDR:  n.addr  = pwdata[21:0];
        `FCD_OFS_WDATA: n.wdata = pwdata[15:0];
        default: ;
      endcase
    end
    if (wr_take && paddr == `FCD_OFS_STATUS && pwdata[`FCD_ST_DONE]) begin
      n.done = 1'b0;
    end
    case (q.st)
      fcd_pkg::FCD_S_IDLE: begin
        if (go) begin
          n.idx  = 3'h0;
          n.busy = 1'b1;
          n.fail = 1'b0;
          n.tmo  = 1'b0;
          n.st   = fcd_pkg::FCD_S_ISSUE;
        end
      end
      fcd_pkg::FCD_S_ISSUE: begin
        n.c_rd    = (s.kind == fcd_pkg::FCD_K_RD);
        n.c_addr  = {10'h000, s.addr};
        n.c_wdata = {8'h00, s.data};
        if (s.kind == fcd_pkg::FCD_K_WU || s.kind == fcd_pkg::FCD_K_WA || s.kind == fcd_pkg::FCD_K_RD) begin
          n.c_addr = q.addr;
        end
        if (s.kind == fcd_pkg::FCD_K_WU) begin
          n.c_wdata = q.wdata;
        end
        if (s.kind == fcd_pkg::FCD_K_END) begin
          n.st = is_poll(q.cmd) ? fcd_pkg::FCD_S_POLL : fcd_pkg::FCD_S_IDLE;
          if (!is_poll(q.cmd)) begin
            n.busy = 1'b0;
            n.done = 1'b1;
          end
        end else begin
          n.c_start = 1'b1;
          n.st      = fcd_pkg::FCD_S_CWAIT;
        end
      end
      fcd_pkg::FCD_S_CWAIT: begin
        if (c_done) begin
          if (q.c_rd) begin
            n.rdata = c_rdata;
          end
          n.idx = q.idx + 3'h1;
          n.st  = fcd_pkg::FCD_S_ISSUE;
        end
      end
      fcd_pkg::FCD_S_POLL: begin
        n.c_start = 1'b1;
        n.c_rd    = 1'b1;
        n.c_addr  = q.addr;  // R18 R20
        n.st      = fcd_pkg::FCD_S_PWAIT;
      end
      fcd_pkg::FCD_S_PWAIT: begin
        if (c_done) begin
          n.c_start = 1'b1;
          if (c_rdata[`FCD_BIT_POLL] == target) begin
            // low bits may still be stale when the polling bit flips
            n.c_rd = 1'b1;  // R22
            n.st   = fcd_pkg::FCD_S_FWAIT;
          end else if (c_rdata[`FCD_BIT_TMO] && q.tmo) begin
            n.c_rd    = 1'b0;
            n.c_addr  = `FCD_RST_ADDR;
            n.c_wdata = {8'h00, `FCD_D_RST};  // R04
            n.fail    = 1'b1;
            n.st      = fcd_pkg::FCD_S_AWAIT;
          end else begin
            // flag seen once: recheck the polling bit before giving up
            n.tmo     = c_rdata[`FCD_BIT_TMO];
            n.c_start = 1'b0;
            n.st      = fcd_pkg::FCD_S_POLL;
          end
        end
      end
      fcd_pkg::FCD_S_FWAIT, fcd_pkg::FCD_S_AWAIT: begin
        if (c_done) begin
          if (q.st == fcd_pkg::FCD_S_FWAIT) begin
            n.rdata = c_rdata;
          end
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st   = fcd_pkg::FCD_S_IDLE;
        end
      end
      default: n.st = fcd_pkg::FCD_S_IDLE;
    endcase
    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    n.pready  = psel && penable && !q.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h00000000;
    if (psel && penable && !q.pready) begin
      case (paddr)
        `FCD_OFS_CTRL:   n.prdata = {28'h0000000, q.cmd};
        `FCD_OFS_ADDR:   n.prdata = {10'h000, q.addr};
        `FCD_OFS_WDATA:  n.prdata = {16'h0000, q.wdata};
        `FCD_OFS_RDATA:  n.prdata = {16'h0000, q.rdata};
        `FCD_OFS_STATUS: n.prdata = {27'h0000000, q.tmo, q.rdy, q.fail, q.done, q.busy};
        default:         n.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: fcd_pkg::FCD_S_IDLE, cmd: fcd_pkg::FCD_C_READ, rdy: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  fcd_cycle u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (q.c_start),
    .rd      (q.c_rd),
    .addr    (q.c_addr),
    .wdata   (q.c_wdata),
    .dq_i    (flash_dq_i),
    .done    (c_done),
    .rdata   (c_rdata),
    .fl_addr (flash_addr),
    .dq_o    (flash_dq_o),
    .dq_oe   (flash_dq_oe),
    .ce_n    (flash_ce_n),
    .we_n    (flash_we_n),
    .oe_n    (flash_oe_n)
  );

  assign pready  = q.pready;
  assign prdata  = q.prdata;
  assign pslverr = q.pslverr;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_issue(fcd_pkg::fcd_cmd_t c, logic [2:0] i);
    q.st == fcd_pkg::FCD_S_ISSUE && q.cmd == c && q.idx == i;
  endsequence

  chk_unlock_addr: assert property (q.c_start && s.kind == fcd_pkg::FCD_K_W && q.c_wdata == 16'h00AA // R01
                                     |-> q.c_addr == 22'h000555)
    else $error("unlock AA write not at 555");
  chk_asel_read: assert property (s_issue(fcd_pkg::FCD_C_ASEL, 3'h3) |=> q.c_start && q.c_rd) // R02
    else $error("autoselect fourth cycle not a read");
  chk_prog_word: assert property (s_issue(fcd_pkg::FCD_C_PROG, 3'h3) |=> q.c_addr == q.addr && q.c_wdata == q.wdata) // R08
    else $error("program word not sent to program address");
  chk_byp_prog: assert property (s_issue(fcd_pkg::FCD_C_BYP_PROG, 3'h0) |=> q.c_wdata == 16'h00A0 ##1 !q.c_start [*3]) // R10
    else $error("bypass program does not open with A0");
  chk_byp_exit: assert property (s_issue(fcd_pkg::FCD_C_BYP_OFF, 3'h1) |=> q.c_start && q.c_wdata == 16'h0000) // R11
    else $error("bypass exit second write not 00");
  chk_erase_last: assert property (s_issue(fcd_pkg::FCD_C_CHIP, 3'h5) |=> q.c_addr == 22'h000555 && q.c_wdata == 16'h0010) // R12
    else $error("chip erase sixth write wrong");
  chk_poll_done: assert property (q.st == fcd_pkg::FCD_S_PWAIT && c_done && c_rdata[7] == target
                                   |=> q.st == fcd_pkg::FCD_S_FWAIT && q.c_start && q.c_rd) // R18 R20 R22
    else $error("polling completion not followed by a further read");
  chk_abort_reset: assert property ($rose(q.st == fcd_pkg::FCD_S_AWAIT) |-> q.c_wdata == 16'h00F0 && q.fail
                                     ##1 !flash_ce_n [*3]) // R04
    else $error("timeout not answered with reset write");
  chk_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");
endmodule : fcd_ctrl
`default_nettype wire

/* fcd_ctrl_tb.sv */
// fcd_ctrl_tb.sv: self-checking bench of fcd_ctrl over APB
// assumes fcd_flash_model on the flash pins, one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "fcd_map.svh"
module fcd_ctrl_tb;
  localparam logic [15:0] MFR = 16'h00A5; // arbitrary value
  localparam logic [15:0] DEV = 16'h5A11; // arbitrary value
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, dq_oe, ce_n, we_n, oe_n, rb, e;
  logic [21:0] fa;
  logic [15:0] dq_o, dq_i;
  logic [3:0]  cl [4] = '{4'h9, 4'hA, 4'hB, 4'hC};
  logic [4:0]  xs = 5'h0A;
  int          err_count = 0, comparisons = 0, cyc = 0;
  initial forever #10 pclk = ~pclk;
  fcd_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .flash_addr(fa),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .ready_busy_in(rb));
  fcd_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .POLLS(3)) u_fl (.addr(fa), .dq(dq_o), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .dq_i(dq_i), .rb(rb));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic s);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    s = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // issue one command and wait for done, then leave RDATA in r
  task automatic run(input logic [3:0] c, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, `FCD_OFS_ADDR, {10'h000, a}, r, e);
    apb(1'b1, `FCD_OFS_WDATA, {16'h0000, d}, r, e);
    apb(1'b1, `FCD_OFS_STATUS, 32'h0000_0002, r, e);
    apb(1'b1, `FCD_OFS_CTRL, {23'h000000, 1'b1, 4'h0, c}, r, e);
    do begin apb(1'b0, `FCD_OFS_STATUS, 32'h0, r, e); n++; end while (r[1] !== 1'b1 && n < 500);
    chk(r[4:0], xs);
    apb(1'b0, `FCD_OFS_RDATA, 32'h0, r, e);
  endtask : run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      $display("MISMATCH t=%0t run too long", $time);
      finish_test;
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FCD_OFS_STATUS, 32'h0, r, e);
    chk(r, 32'h0000_0008);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk({r[30:0], e}, 32'h0000_0001);
    $display("registers done");
    run(4'h3, 22'h012345, 16'h5A7C);
    chk(r, 32'h0000_5A7C);
    run(4'h0, 22'h012345, 16'h0000);
    chk(r, 32'h0000_5A7C);
    run(4'h0, 22'h3FF100, 16'h0000);
    chk(r, 32'h0000_FFFF);
    $display("program done");
    run(4'h2, 22'h3FF000, 16'h0000);
    chk(r, {16'h0000, MFR});
    run(4'h2, 22'h000001, 16'h0000);
    chk(r, {16'h0000, DEV});
    run(4'h1, 22'h000000, 16'h0000);
    run(4'h0, 22'h012345, 16'h0000);
    chk(r, 32'h0000_5A7C);
    $display("autoselect done");
    run(4'h4, 22'h000000, 16'h0000);
    run(4'h5, 22'h201000, 16'h8001);
    run(4'h6, 22'h000000, 16'h0000);
    run(4'h0, 22'h201000, 16'h0000);
    chk(r, 32'h0000_8001);
    $display("bypass done");
    run(4'h7, 22'h012345, 16'h0000);
    chk(r, 32'h0000_FFFF);
    run(4'h3, 22'h012345, 16'h1234);
    run(4'h8, 22'h010000, 16'h0000);
    chk(r, 32'h0000_FFFF);
    run(4'h3, 22'h012345, 16'h1200);
    xs = 5'h1E;
    run(4'h3, 22'h012345, 16'h12FF);
    chk(r, 32'h0000_1200);
    xs = 5'h0A;
    run(4'h3, 22'h3F8010, 16'h0080);
    chk(r, 32'h0000_FFFF);
    run(4'h8, 22'h3F8000, 16'h0000);
    run(4'h0, 22'h012345, 16'h0000);
    chk(r, 32'h0000_1200);
    $display("erase done");
    run(4'h2, 22'h3F8002, 16'h0000);
    chk(r, 32'h0000_0001);
    foreach (cl[i]) run(cl[i], 22'h000055, 16'h0000);
    run(4'h0, 22'h000002, 16'h0000);
    chk(r, 32'h0000_0018);
    run(4'hD, 22'h000000, 16'h0000);
    run(4'h1, 22'h000000, 16'h0000);
    run(4'h0, 22'h201000, 16'h0000);
    chk(r, 32'h0000_FFFF);
    $display("single commands done");
    finish_test;
  end
endmodule : fcd_ctrl_tb
`default_nettype wire

/* fcd_cycle.sv */
// fcd_cycle.sv: one flash bus cycle, write or read, with timed strobes
// assumes flash data inputs already synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
`include "fcd_map.svh"
module fcd_cycle (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        rd,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] dq_i,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [21:0]      fl_addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n
);
  fcd_pkg::fcd_cyc_t q;
  fcd_pkg::fcd_cyc_t n;
  logic [2:0]        lim;

  always_comb begin
    n      = q;
    n.done = 1'b0;
    lim    = q.rd ? 3'(`FCD_ACC_CYC) : 3'(`FCD_WP_CYC);
    case (q.st)
      fcd_pkg::FCD_Y_IDLE: begin
        if (start) begin
          n.addr  = addr;
          n.dq_o  = wdata;
          n.rd    = rd;
          n.ce_n  = 1'b0;
          n.dq_oe = ~rd;
          n.st    = fcd_pkg::FCD_Y_SETUP;
        end
      end
      fcd_pkg::FCD_Y_SETUP: begin
        // address settles a full cycle before the strobe falls
        n.we_n = q.rd;  // R09
        n.oe_n = ~q.rd;
        n.cnt  = 3'h1;
        n.st   = fcd_pkg::FCD_Y_STRB;
      end
      fcd_pkg::FCD_Y_STRB: begin
        n.cnt = q.cnt + 3'h1;
        if (q.cnt >= lim) begin
          if (q.rd) begin
            n.rdata = dq_i;
          end
          n.we_n = 1'b1;
          n.oe_n = 1'b1;
          n.st   = fcd_pkg::FCD_Y_HOLD;
        end
      end
      fcd_pkg::FCD_Y_HOLD: begin
        // data held past the write strobe rise, dropped with chip select
        n.ce_n  = 1'b1;  // R09
        n.dq_oe = 1'b0;
        n.done  = 1'b1;
        n.st    = fcd_pkg::FCD_Y_IDLE;
      end
      default: n.st = fcd_pkg::FCD_Y_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: fcd_pkg::FCD_Y_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  assign done    = q.done;
  assign rdata   = q.rdata;
  assign fl_addr = q.addr;
  assign dq_o    = q.dq_o;
  assign dq_oe   = q.dq_oe;
  assign ce_n    = q.ce_n;
  assign we_n    = q.we_n;
  assign oe_n    = q.oe_n;
endmodule : fcd_cycle
`default_nettype wire

/* fcd_flash_model.sv */
// fcd_flash_model.sv: behavioural NOR flash standing on the far side of fcd_ctrl
// assumes registered strobes from the controller and no pull-up on the data bus
`timescale 1ns/1ns
`default_nettype none
module fcd_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h5A11, // arbitrary value
  parameter logic [6:0]  PROT_SEC = 7'h7F,
  parameter int          POLLS    = 3
) (
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  output logic [15:0]      dq_i,
  output logic             rb
);
  logic [15:0] mem [logic [21:0]];
  logic [21:0] la;
  logic [15:0] pw;
  logic [7:0]  d;
  int          cyc = 0, busy = 0, ers = 0, mode = 0, es = 0, pend = 0, susp = 0, off = 0;
  logic        tf = 1'b0, tg = 1'b0;
  initial dq_i = 16'h0000;
  assign rb = (busy == 0);
  always @(negedge we_n) if (!ce_n) la = addr;
  always @(posedge we_n) if (!ce_n) begin
    d = dq[7:0];
    if (tf) begin
      if (d == 8'hF0) begin tf = 1'b0; busy = 0; end
    end else if (busy > 0) begin
      if (d == 8'hB0 && ers == 2) begin busy = 0; susp = 1; end
    end else if (pend) begin
      pw = dq; busy = POLLS; ers = 0; pend = 0;
      // a one over a programmed zero never verifies
      tf = mem.exists(la) && (dq & ~mem[la]) != 16'h0000;
      if (la[21:15] != PROT_SEC && !tf) mem[la] = dq;
    end else if (d == 8'hF0) begin cyc = 0; mode = 0; es = 0; end
    else if (mode == 2) begin
      if (d == 8'hA0) pend = 1;
      if (d == 8'h00 && off) mode = 0;
      off = (d == 8'h90);
    end else if (d == 8'h30 && susp && cyc == 0) begin susp = 0; busy = POLLS; ers = 2; end
    else if (cyc == 0) begin
      if (la[11:0] == 12'h055 && d == 8'h98) mode = 3;
      if (mode == 5 && d == 8'h00) mode = 0;
      cyc = (la[11:0] == 12'h555 && d == 8'hAA) ? 1 : 0;
    end else if (cyc == 1) cyc = (la[11:0] == 12'h2AA && d == 8'h55) ? 2 : 0;
    else begin
      cyc = 0;
      // whole array cleared by chip erase and by sector erase outside PROT_SEC: keeps the model small
      if (es) begin
        es = 0;
        if (d == 8'h10 || d == 8'h30) begin busy = POLLS; ers = (d == 8'h30) ? 2 : 1; end
        if (d == 8'h10 || (d == 8'h30 && la[21:15] != PROT_SEC)) mem.delete();
      end else if (la[11:0] == 12'h555) begin
        case (d)
          8'h90: mode = (mode == 4) ? 5 : 1;
          8'hA0: pend = 1;
          8'h20: mode = 2;
          8'h80: es = 1;
          8'h88: mode = 4;
          default: ;
        endcase
      end
    end
  end
  always @(negedge oe_n) if (!ce_n) begin
    if (busy > 0) dq_i = {8'h00, (ers != 0) ? 1'b0 : ~pw[7], tg, tf, 5'h00};
    else if (mode == 1) dq_i = (addr[7:0] == 8'h00) ? MFR_CODE : (addr[7:0] == 8'h01) ? DEV_CODE :
                               (addr[7:0] == 8'h02) ? {15'h0000, addr[21:15] == PROT_SEC} : 16'h0000;
    else if (mode == 4 && addr[7:0] == 8'h02) dq_i = 16'h0018;
    else dq_i = mem.exists(addr) ? mem[addr] : 16'hFFFF;
  end
  // released bus shows the inverse, never a stale copy
  always @(posedge oe_n) begin dq_i = ~dq_i; tg = ~tg; if (busy > 0 && !tf) busy--; end
endmodule : fcd_flash_model
`default_nettype wire

/* fcd_map.svh */
// fcd_map.svh: offsets, fields, command bytes and timing counts of the flash command driver
// assumes a 50 MHz pclk and a parallel NOR flash with a 16-bit data bus
//
// Function
// R01 - unlock writes use only low address 555 or 2AA; upper bits ignored
// R02 - all command cycles are writes except plain read and autoselect fourth cycle
// R03 - in read mode one read cycle returns array data, no commands first
// R04 - one F0 write anywhere returns device to read or suspended-read mode
// R05 - autoselect: AA@555, 55@2AA, 90@555, then read X00 or X01
// R06 - autoselect read at sector X02 gives 00h unprotected or 01h protected
// R07 - secured-region lock indicator reads 98h/18h or 88h/08h by guard position
// R08 - program: AA@555, 55@2AA, A0@555, then word to program address
// R09 - device latches address on later falling strobe, data on earlier rising
// R10 - bypass entry AA, 55, 20 first; then program is A0 then word
// R11 - leave bypass by writing 90 then 00 anywhere; device goes to read
// R12 - erase: AA, 55, 80, AA, 55, then 10@555 chip or 30@sector
// R13 - device selects sector with address bits 21 to 15 only
// R14 - B0 anywhere suspends a running sector erase, ignored otherwise
// R15 - while suspended device allows reads, programs elsewhere and autoselect
// R16 - 30 anywhere resumes a suspended erase, only valid while suspended
// R17 - 98 written at 55 enters query mode from read or autoselect
// R18 - program polling bit shows complement of data bit 7 until done
// R19 - program to protected sector polls about 1 us then read mode
// R20 - erase polling bit reads 0 while erasing, 1 when done or suspended
// R21 - all selected sectors protected: polls about 100 us then read mode
// R22 - after polling shows completion host reads once more for valid data
// R23 - ready/busy output low during embedded program or erase
// R24 - timeout flag bit reads 1 when pulse limit exceeded
// R25 - toggle bit one flips every read during program or erase
// R26 - mismatching write abandons partial sequence back to prior read state
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH

// ----------------------------------------
// registers
// ----------------------------------------
`define FCD_OFS_CTRL    8'h00
`define FCD_OFS_ADDR    8'h04
`define FCD_OFS_WDATA   8'h08
`define FCD_OFS_RDATA   8'h0C
`define FCD_OFS_STATUS  8'h10
`define FCD_CTRL_GO     8
`define FCD_ST_BUSY     0
`define FCD_ST_DONE     1
`define FCD_ST_FAIL     2
`define FCD_ST_RDY      3
`define FCD_ST_TMO      4
`define FCD_RST_ADDR    22'h000000
`define FCD_RST_DATA    16'h0000

// ----------------------------------------
// command bytes and unlock addresses
// ----------------------------------------
`define FCD_UNL_A1      12'h555
`define FCD_UNL_A2      12'h2AA
`define FCD_CFI_A       12'h055
`define FCD_D_UNL1      8'hAA
`define FCD_D_UNL2      8'h55
`define FCD_D_ASEL      8'h90
`define FCD_D_PROG      8'hA0
`define FCD_D_BYP       8'h20
`define FCD_D_ESET      8'h80
`define FCD_D_CHIP      8'h10
`define FCD_D_SECT      8'h30
`define FCD_D_SUSP      8'hB0
`define FCD_D_RST       8'hF0
`define FCD_D_CFI       8'h98
`define FCD_D_SECR      8'h88
`define FCD_D_ZERO      8'h00
`define FCD_BIT_POLL    7
`define FCD_BIT_TMO     5

// ----------------------------------------
// timing
// ----------------------------------------
`define FCD_CLK_NS      20
`define FCD_T_WP_NS     35
`define FCD_T_ACC_NS    90
`define FCD_WP_CYC      ((`FCD_T_WP_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_ACC_CYC     ((`FCD_T_ACC_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)

`endif

/* fcd_pkg.sv */
// fcd_pkg.sv: types of the flash command driver
// assumes fcd_map.svh for all numeric constants
package fcd_pkg;
  typedef enum logic [3:0] {
    FCD_C_READ = 4'h0, FCD_C_RESET = 4'h1, FCD_C_ASEL = 4'h2, FCD_C_PROG = 4'h3,
    FCD_C_BYP_ON = 4'h4, FCD_C_BYP_PROG = 4'h5, FCD_C_BYP_OFF = 4'h6, FCD_C_CHIP = 4'h7,
    FCD_C_SECT = 4'h8, FCD_C_SUSP = 4'h9, FCD_C_RESUME = 4'hA, FCD_C_CFI = 4'hB,
    FCD_C_SEC_ON = 4'hC, FCD_C_SEC_OFF = 4'hD
  } fcd_cmd_t;

  typedef enum logic [2:0] {
    FCD_K_END = 3'h0, FCD_K_W = 3'h1, FCD_K_WU = 3'h2, FCD_K_WA = 3'h3, FCD_K_RD = 3'h4
  } fcd_kind_t;

  typedef struct packed {
    fcd_kind_t   kind;
    logic [11:0] addr;
    logic [7:0]  data;
  } fcd_step_t;

  typedef enum logic [3:0] {
    FCD_Y_IDLE = 4'b0001, FCD_Y_SETUP = 4'b0010, FCD_Y_STRB = 4'b0100, FCD_Y_HOLD = 4'b1000
  } fcd_cyc_st_t;

  typedef enum logic [6:0] {
    FCD_S_IDLE = 7'b0000001, FCD_S_ISSUE = 7'b0000010, FCD_S_CWAIT = 7'b0000100,
    FCD_S_POLL = 7'b0001000, FCD_S_PWAIT = 7'b0010000, FCD_S_FWAIT = 7'b0100000,
    FCD_S_AWAIT = 7'b1000000
  } fcd_st_t;

  typedef struct packed {
    fcd_cyc_st_t st;
    logic [2:0]  cnt;
    logic        rd;
    logic [21:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [15:0] rdata;
    logic        done;
  } fcd_cyc_t;

  typedef struct packed {
    fcd_st_t     st;
    fcd_cmd_t    cmd;
    logic [2:0]  idx;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        busy;
    logic        done;
    logic        fail;
    logic        tmo;
    logic        rdy;
    logic        c_start;
    logic        c_rd;
    logic [21:0] c_addr;
    logic [15:0] c_wdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } fcd_ctl_t;
endpackage : fcd_pkg
